// File: analog_comparator_control.v
// Comparator control wrapper: Wishbone registers, hold, edge flag, pin and timer link
//
// Notes on behaviour
// - Setting enable freezes result, flag and timer link for 128 bus clocks.
// - Same 128 clock hold on every return to normal, including leaving stop.
// - Disabled or stop means shutdown; last result stays on the result path.
// - Comparator runs only when enabled and not stopped; wait mode changes nothing.
// - In shutdown with non-inverted polarity the output pin is driven low.
// - Output pin enable drives the result out when 1, releases pin when 0.
// - Polarity bit passes the result straight at 0, inverted at 1.
// - Filter select picks low speed filter at 0, high speed at 1.
// - Two-bit hysteresis code goes to the analog core unchanged.
// - Edge mode 00 none, 01 rising, 10 falling, 11 both edges set flag.
// - Each comparator input chosen from two external pins and two internal signals.
// - Result drives the timer input capture link for timestamping.
// - Select codes 00,01 external, 10,11 internal; writable only while disabled.
// - Flag sets two clocks after qualifying edge; cleared by writing one.
// - Interrupt request is flag AND interrupt enable.
// - Result bit reads the held result; writes to it are ignored.
`include "cmp_ctrl_regs.vh"
module analog_comparator_control #(
    parameter [6:0] HOLD_CYCLES = `INIT_HOLD_CYCLES
) (
    input  wire        clock_in,         // Bus clock 100 MHz
    input  wire        rstn_in,          // Async reset, active low
    input  wire        clk_en_in,        // Clock enable, freezes all state when low
    input  wire        stop_mode_in,     // Chip in stop mode
    input  wire        wait_mode_in,     // Chip in wait mode, no effect
    input  wire        wb_cyc_i,         // Wishbone cycle
    input  wire        wb_stb_i,         // Wishbone strobe
    input  wire        wb_we_i,          // Wishbone write enable
    input  wire [31:0] wb_adr_i,         // Wishbone byte address
    input  wire [3:0]  wb_sel_i,         // Wishbone byte selects
    input  wire [31:0] wb_dat_i,         // Wishbone write data
    output reg  [31:0] wb_dat_o,         // Wishbone read data
    output reg         wb_ack_o,         // Wishbone acknowledge
    output wire        wb_err_o,         // Wishbone error, unused map
    input  wire        core_result_in,   // Raw asynchronous comparator output
    output wire        core_power_on_out,// Analog core powered, normal mode
    output wire        filter_speed_sel_out, // Input filter speed to core
    output wire [1:0]  hysteresis_sel_out,   // Hysteresis code to core
    output wire [1:0]  pos_input_sel_out,    // Positive input mux select
    output wire [1:0]  neg_input_sel_out,    // Negative input mux select
    output wire        timer_capture_out,    // Held result to timer capture
    output wire        compare_out_pin_out,  // Output pin level
    output wire        compare_out_pin_oe_n_out, // Output pin enable, low drives
    output wire        irq_out               // Interrupt request
);
    // Register storage
    reg  [7:0] control_main_reg;
    reg  [7:0] input_routing_reg;
    reg        irq_on_reg;
    reg        event_flag_reg;
    reg        held_result_reg;
    reg        held_prev_reg;
    reg        edge_seen_reg;

    wire       sync_result;
    wire       holding;
    wire       comparator_on = control_main_reg[`BIT_COMPARATOR_ON];
    wire       normal_mode   = comparator_on && !stop_mode_in;
    wire [1:0] flag_edge_sel = control_main_reg[`EDGE_MSB:`EDGE_LSB];
    wire       output_invert = control_main_reg[`BIT_OUTPUT_INVERT];
    wire       output_pin_on = control_main_reg[`BIT_OUTPUT_PIN_ON];

    // Bus decode: word index, upper reserved indices read zero, beyond is an error
    wire       bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [2:0] word_idx  = wb_adr_i[`IDX_MSB:`IDX_LSB];
    wire       addr_high = (wb_adr_i[31:5] != 27'h0000000) || (wb_adr_i[1:0] != 2'h0);
    wire       mapped    = !addr_high && (word_idx <= `RSV_INDEX_LAST);
    wire       wr_lane0  = bus_req && mapped && wb_we_i && wb_sel_i[0] && !word_idx[2];
    wire [1:0] reg_idx   = word_idx[1:0];

    // Checks whether a transition matches the selected edge mode
    function edge_match;
        input [1:0] mode;
        input       prev;
        input       curr;
        begin
            case (mode)
                `EDGE_RISE: edge_match = !prev && curr;
                `EDGE_FALL: edge_match = prev && !curr;
                `EDGE_BOTH: edge_match = prev ^ curr;
                default:    edge_match = 1'b0;
            endcase
        end
    endfunction

    sync_two_stage u_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .enable_in(clk_en_in),
        .async_in (core_result_in),
        .sync_out (sync_result)
    );

    hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
        .clock_in   (clock_in),
        .rstn_in    (rstn_in),
        .enable_in  (clk_en_in),
        .active_in  (normal_mode),
        .holding_out(holding)
    );

    // Control registers; routing writes only land while disabled
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            control_main_reg  <= `RST_CONTROL_MAIN;
            input_routing_reg <= `RST_INPUT_ROUTING;
            irq_on_reg        <= `RST_IRQ_ON;
        end else if (clk_en_in && wr_lane0) begin
            case (reg_idx)
                `OFS_CONTROL_MAIN:  control_main_reg <= wb_dat_i[7:0];
                `OFS_INPUT_ROUTING: begin
                    if (!comparator_on)
                        input_routing_reg <= wb_dat_i[7:0] & `ROUTING_MASK;
                end
                `OFS_IRQ_ENABLE:    irq_on_reg <= wb_dat_i[`BIT_IRQ_ON];
                default:            ;    // Status result bit is read only
            endcase
        end
    end

    // Held result path: frozen during hold and shutdown, live otherwise
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            held_result_reg <= `RST_HOLD_LEVEL;
        end else if (clk_en_in && !holding) begin
            held_result_reg <= sync_result;
        end
    end

    // Edge detect on the held result; flag lags the edge by two clocks
    // The first stage registers the match, the second sets the flag
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            held_prev_reg  <= `RST_HOLD_LEVEL;
            edge_seen_reg  <= 1'b0;
            event_flag_reg <= 1'b0;
        end else if (clk_en_in) begin
            held_prev_reg <= held_result_reg;
            edge_seen_reg <= edge_match(flag_edge_sel, held_prev_reg, held_result_reg);
            // Set wins over a simultaneous write-one clear
            if (edge_seen_reg)
                event_flag_reg <= 1'b1;
            else if (wr_lane0 && reg_idx == `OFS_STATUS && wb_dat_i[`BIT_EVENT_FLAG])
                event_flag_reg <= 1'b0;
        end
    end

    // Read mux and single-cycle acknowledge
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `ZERO_32;
        end else if (clk_en_in) begin
            wb_ack_o <= bus_req && mapped;
            if (bus_req && mapped && !wb_we_i) begin
                wb_dat_o <= `ZERO_32;
                if (!word_idx[2]) begin
                    case (reg_idx)
                        `OFS_CONTROL_MAIN:  wb_dat_o[7:0] <= control_main_reg;
                        `OFS_INPUT_ROUTING: wb_dat_o[7:0] <= input_routing_reg;
                        `OFS_IRQ_ENABLE:    wb_dat_o[`BIT_IRQ_ON] <= irq_on_reg;
                        default: begin
                            wb_dat_o[`BIT_RESULT]     <= held_result_reg;
                            wb_dat_o[`BIT_EVENT_FLAG] <= event_flag_reg;
                        end
                    endcase
                end
            end
        end
    end

    // Error answer for addresses outside the block; combinational handshake
    assign wb_err_o = wb_cyc_i && wb_stb_i && !mapped;

    // Analog core controls
    assign core_power_on_out    = normal_mode;
    assign filter_speed_sel_out = control_main_reg[`BIT_FILTER_SPEED];
    assign hysteresis_sel_out   = control_main_reg[`HYST_MSB:`HYST_LSB];
    assign pos_input_sel_out    = input_routing_reg[`POS_SEL_MSB:`POS_SEL_LSB];
    assign neg_input_sel_out    = input_routing_reg[`NEG_SEL_MSB:`NEG_SEL_LSB];

    // Timer link carries the held result
    assign timer_capture_out = held_result_reg;

    // Pin: zero in shutdown before polarity, so it reads high only when inverted
    assign compare_out_pin_out      = (normal_mode ? held_result_reg : 1'b0) ^ output_invert;
    assign compare_out_pin_oe_n_out = !output_pin_on;

    // Interrupt
    assign irq_out = event_flag_reg && irq_on_reg;
endmodule // analog_comparator_control

// File: analog_comparator_control_properties.sv
// Port-level checker for the comparator control block, with its bind
module analog_comparator_control_checker #(
    parameter [6:0] HOLD_CYCLES = 7'h7F
) (
    input wire        clock_in,          // Bus clock
    input wire        rstn_in,           // Async reset, active low
    input wire        stop_mode_in,      // Stop mode
    input wire        wb_cyc_i,          // Cycle
    input wire        wb_stb_i,          // Strobe
    input wire [31:0] wb_adr_i,          // Byte address
    input wire        wb_ack_o,          // Acknowledge
    input wire        wb_err_o,          // Error
    input wire        core_result_in,    // Raw level
    input wire        core_power_on_out, // Normal mode
    input wire        timer_capture_out  // Held result
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] on_cnt;
    // Cycles spent in normal mode, saturating so long runs never wrap
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) on_cnt <= 8'h00;
        else if (!core_power_on_out) on_cnt <= 8'h00;
        else if (on_cnt != 8'hFF) on_cnt <= on_cnt + 8'h01;
    end
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_AFTER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o)
        else $error("mapped request not answered next cycle");
    AST_NO_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_ERR_MAP: assert property (wb_cyc_i && wb_stb_i && wb_adr_i[1:0] == 2'h0
        |-> wb_err_o == (wb_adr_i > 32'h1F))
        else $error("error flag disagrees with address map");
    AST_STOP_OFF: assert property (stop_mode_in |-> !core_power_on_out)
        else $error("core powered in stop mode");
    AST_HOLD: assert property (core_power_on_out && on_cnt != 8'h00 && on_cnt < {1'b0, HOLD_CYCLES}
        |-> $stable(timer_capture_out))
        else $error("result moved during initialization hold");
    AST_SHUT_KEEP: assert property (!core_power_on_out && !$past(core_power_on_out)
        && !$past(core_power_on_out, 2) |-> $stable(timer_capture_out))
        else $error("result moved in shutdown");
    AST_SYNC_LAT: assert property ($changed(timer_capture_out)
        |-> timer_capture_out == $past(core_result_in, 3))
        else $error("result not three stages behind raw input");
endmodule // analog_comparator_control_checker
bind analog_comparator_control analog_comparator_control_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.*);

// File: analog_comparator_control_tb_top.sv
// Self-checking bench for the comparator control block
module analog_comparator_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [6:0] HOLD = 7'h04;
    logic clock_in = 1'b0, rstn_in = 1'b0, stop_m = 1'b0, wait_m = 1'b0, last_err = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, src = 32'h40404040;
    logic [7:0] q;
    wire [31:0] rdat;
    wire ack, err, raw, pwr, filt, tcap, pin, oe_n, irq;
    wire [1:0] hyst, psel, nsel;
    int errors = 0, n_compared = 0, n;
    analog_comparator_control #(.HOLD_CYCLES(HOLD)) u_analog_comparator_control (.clock_in(clock_in),
        .rstn_in(rstn_in), .clk_en_in(1'b1), .stop_mode_in(stop_m), .wait_mode_in(wait_m), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .core_result_in(raw), .core_power_on_out(pwr),
        .filter_speed_sel_out(filt), .hysteresis_sel_out(hyst), .pos_input_sel_out(psel),
        .neg_input_sel_out(nsel), .timer_capture_out(tcap), .compare_out_pin_out(pin),
        .compare_out_pin_oe_n_out(oe_n), .irq_out(irq));
    comparator_core_model u_comparator_core_model (.power_in(pwr), .pos_sel_in(psel),
        .neg_sel_in(nsel), .src_in(src), .result_out(raw));
    initial forever #5 clock_in = ~clock_in;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Classic single cycle; request held until ack or err is sampled
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge clock_in);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, 24'h0, a, 24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clock_in);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        if (i == 20) begin errors++; test_done; end
        q = rdat[7:0];
        last_err = err;
        {cyc, stb} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
    task rd(input logic [7:0] a, input logic [7:0] e); bus(1'b0, a, 8'h00); chk(q, e); endtask
    task set_res(input logic v); @(posedge clock_in); src[23:16] <= v ? 8'hC0 : 8'h20; endtask
    // Bounded wait for the held result; n returns the cycles taken
    task wait_tcap(input logic v);
        for (n = 0; n < 60 && tcap !== v; n++) @(negedge clock_in);
        if (n == 60) begin errors++; test_done; end
    endtask
    task t_reset;
        rd(8'h00, 8'h00); rd(8'h04, 8'h00); rd(8'h08, 8'h00); rd(8'h0C, 8'h00);
        chk(oe_n, 1'b1);
        chk(pin, 1'b0);
        wr(8'h04, 8'h21);
        rd(8'h04, 8'h21);
        chk(psel, 2'h2);
        chk(nsel, 2'h1);
    endtask
    task t_enable_hold;
        set_res(1'b1);
        repeat (8) @(negedge clock_in);
        chk(tcap, 1'b0);
        wr(8'h00, 8'hD9);
        chk(filt, 1'b1);
        chk(hyst, 2'h2);
        chk(oe_n, 1'b0);
        wait_tcap(1'b1);
        chk(n >= HOLD, 1'b1);
        chk(pin, 1'b1);
        repeat (3) @(negedge clock_in);
        rd(8'h0C, 8'h81);
        wr(8'h04, 8'h13);
        rd(8'h04, 8'h21);
        wr(8'h08, 8'h01);
        chk(irq, 1'b1);
        wr(8'h0C, 8'h81);
        rd(8'h0C, 8'h80);
        chk(irq, 1'b0);
    endtask
    // Each edge mode sees one fall then one rise
    task t_edge_modes;
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, 8'hD8 | m[7:0]);
            wr(8'h0C, 8'h01);
            set_res(1'b0);
            wait_tcap(1'b0);
            repeat (3) @(negedge clock_in);
            rd(8'h0C, {7'h00, m[1]});
            wr(8'h0C, 8'h01);
            set_res(1'b1);
            wait_tcap(1'b1);
            repeat (3) @(negedge clock_in);
            rd(8'h0C, {7'h40, m[0]});
        end
    endtask
    task t_stop_wait;
        @(posedge clock_in) wait_m <= 1'b1;
        @(negedge clock_in) chk(pwr, 1'b1);
        @(posedge clock_in) stop_m <= 1'b1;
        @(negedge clock_in) chk(pwr, 1'b0);
        chk(pin, 1'b0);
        set_res(1'b0);
        repeat (8) @(negedge clock_in);
        chk(tcap, 1'b1);
        @(posedge clock_in) stop_m <= 1'b0;
        wait_tcap(1'b0);
        chk(n >= HOLD, 1'b1);
        wait_m <= 1'b0;
    endtask
    task t_invert_unmapped;
        wr(8'h00, 8'h20);
        chk(pin, 1'b1);
        rd(8'h10, 8'h00);
        bus(1'b0, 8'h40, 8'h00);
        chk(last_err, 1'b1);
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_reset;
        t_enable_hold;
        t_edge_modes;
        t_stop_wait;
        t_invert_unmapped;
        test_done;
    end
endmodule // analog_comparator_control_tb_top

// File: cmp_ctrl_regs.vh
// Register offsets, field positions, reset values and timing constants of the comparator control block
`ifndef CMP_CTRL_REGS_VH
`define CMP_CTRL_REGS_VH
// Register indices; byte address is four times the index
`define OFS_CONTROL_MAIN      2'h0
`define OFS_INPUT_ROUTING     2'h1
`define OFS_IRQ_ENABLE        2'h2
`define OFS_STATUS            2'h3
`define IDX_MSB               3'h4
`define IDX_LSB               2'h2
`define RSV_INDEX_LAST        3'h7
// Main control fields
`define BIT_COMPARATOR_ON     7
`define BIT_OUTPUT_PIN_ON     6
`define BIT_OUTPUT_INVERT     5
`define BIT_FILTER_SPEED      4
`define HYST_MSB              3
`define HYST_LSB              2
`define EDGE_MSB              1
`define EDGE_LSB              0
// Routing fields
`define POS_SEL_MSB           5
`define POS_SEL_LSB           4
`define NEG_SEL_MSB           1
`define NEG_SEL_LSB           0
// Interrupt enable and status fields
`define BIT_IRQ_ON            0
`define BIT_RESULT            7
`define BIT_EVENT_FLAG        0
// Edge modes
`define EDGE_NONE             2'h0
`define EDGE_RISE             2'h1
`define EDGE_FALL             2'h2
`define EDGE_BOTH             2'h3
// Reset values
`define RST_CONTROL_MAIN      8'h00
`define RST_INPUT_ROUTING     8'h00
`define RST_IRQ_ENABLE        8'h00
`define RST_HOLD_LEVEL        1'b0
`define RST_IRQ_ON            1'b0
// Routing bits that exist; the rest read back zero
`define ROUTING_MASK          8'h33
// Initialization hold in bus clocks
`define INIT_HOLD_CYCLES      7'h7F
`define ONE_7                 7'h01
`define ZERO_7                7'h00
`define ZERO_8                8'h00
`define ZERO_32               32'h00000000
`endif

// File: comparator_core_model.sv
// Behavioural analog core with its two input multiplexers
module comparator_core_model (
    input  wire        power_in,   // Core powered
    input  wire [1:0]  pos_sel_in, // Positive mux code
    input  wire [1:0]  neg_sel_in, // Negative mux code
    input  wire [31:0] src_in,     // Bytes 0,1 external pins, 2,3 internal
    output logic       result_out  // Raw compare level
);
    initial result_out = 1'b0;
    // Unpowered core keeps its last level, so no glitch reaches the sync
    always @* begin
        if (power_in)
            result_out = src_in[pos_sel_in * 8 +: 8] > src_in[neg_sel_in * 8 +: 8];
    end
endmodule // comparator_core_model

// File: hold_timer.v
// Counter that holds the result path for a fixed number of bus clocks after entering normal mode
`include "cmp_ctrl_regs.vh"
module hold_timer #(
    parameter [6:0] HOLD_CYCLES = `INIT_HOLD_CYCLES
) (
    input  wire clock_in,   // Bus clock
    input  wire rstn_in,    // Async reset, active low
    input  wire enable_in,  // Clock enable
    input  wire active_in,  // Comparator in normal mode
    output wire holding_out // High while the result path is frozen
);
    reg [6:0] count_reg;
    reg       active_reg;

    // Restart on every entry to normal mode; shut down also holds
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg  <= `ZERO_7;
            active_reg <= 1'b0;
        end else if (enable_in) begin
            active_reg <= active_in;
            if (active_in && !active_reg)
                count_reg <= HOLD_CYCLES;
            else if (count_reg != `ZERO_7)
                count_reg <= count_reg - `ONE_7;
        end
    end

    assign holding_out = !active_in || !active_reg || (count_reg != `ZERO_7);
endmodule // hold_timer

// File: sync_two_stage.v
// Two-flop synchroniser for the asynchronous comparator output
`include "cmp_ctrl_regs.vh"
module sync_two_stage (
    input  wire clock_in,   // Bus clock
    input  wire rstn_in,    // Async reset, active low
    input  wire enable_in,  // Clock enable
    input  wire async_in,   // Unsynchronised level
    output wire sync_out    // Synchronised level
);
    reg first_reg;
    reg second_reg;

    // First flop feeds only the second
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_reg  <= `RST_HOLD_LEVEL;
            second_reg <= `RST_HOLD_LEVEL;
        end else if (enable_in) begin
            first_reg  <= async_in;
            second_reg <= first_reg;
        end
    end

    assign sync_out = second_reg;
endmodule // sync_two_stage
